/* logic/hbridge_params.svh */
// constants for the h-bridge drive and fault control logic
// assumes a 100 MHz ref_clk_i; included by name
`ifndef HBRIDGE_PARAMS_SVH
`define HBRIDGE_PARAMS_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define DEAD_TIME_NS 500
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_BLANK_NS 1000
`define SHORT_BLANK_CYCLES (`SHORT_BLANK_NS / `CLK_PERIOD_NS)
`define CHOP_OFF_NS 20000
`define CHOP_OFF_CYCLES (`CHOP_OFF_NS / `CLK_PERIOD_NS)
// ---------------------------------------------------------------
// reset values and counter width
// ---------------------------------------------------------------
`define SWITCH_RESET 4'h0
`define CNT_W 12
`endif

/* logic/hbridge_pkg.sv */
// types shared by the h-bridge drive and fault control logic
// assumes nothing of its surroundings
package hbridge_pkg;
  typedef enum logic [1:0] {
    drive_off,
    drive_forward,
    drive_reverse,
    drive_brake_high
  } drive_mode_type;

  typedef enum logic [1:0] {
    st_idle,
    st_dead,
    st_run,
    st_fault
  } bridge_state_type;

  typedef logic [3:0] switch_set_type; // {high_a, high_b, low_a, low_b}
endpackage

/* logic/chop_timer.sv */
// fixed off-time chopper for the low-side switches
// assumes limit_hit_i is a synchronous comparator result
`timescale 1ns/100ps
`include "hbridge_params.svh"
module chop_timer #(
  parameter int unsigned OFF_CYCLES = `CHOP_OFF_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // current limit
  input wire logic limit_hit_i,
  output logic chop_o
);
  logic [`CNT_W-1:0] count;

  // start an off window on a limit hit, hold until it runs out
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      chop_o <= 1'b0;
    end else if (count != '0) begin
      count <= count - 1'b1;
      chop_o <= (count != {{(`CNT_W-1){1'b0}}, 1'b1});
    end else if (limit_hit_i) begin
      count <= `CNT_W'(OFF_CYCLES);
      chop_o <= 1'b1;
    end else begin
      chop_o <= 1'b0;
    end
  end
endmodule

/* logic/hbridge_drive_fault_control.sv */
// direction decode, dead time, chopping and fault latch of an h-bridge
// assumes comparator and supply monitor inputs synchronous to ref_clk_i
`timescale 1ns/100ps
`include "hbridge_params.svh"
// Overview of operation
// - enable low with a/b not both low: all switches off, outputs floating.
// - direction change passes through a dead interval with all switches off.
// - input a low turns high b on; input a high turns low b on, unless b is high too: then all switches are off.
// - input b low turns high a on; input b high turns low a on, unless a is high too: then all switches are off.
// - both inputs low brake on supply-side switches whatever enable is.
// - enable pwm gates the decoded drive cycle by cycle.
// - short, overcurrent or overheat detection drives the error flag low and latches all switches off.
// - latch holds until logic supply is cycled.
// - output shorted to supply or ground is detected and latched off.
// - sense voltage above 0.48 V is an overcurrent, entering the latch.
// - logic supply undervoltage near 4 V inhibits drive.
// - motor supply undervoltage near 8.8 V inhibits drive.
// - logic supply falling with enable high reports an error.
// - current chopping switches only the two low-side switches.
// - chop when sense current reaches limit setpoint over 4.9 over sense ohms.
// - short, overcurrent and overheat detectors latch, cleared only by power-on reset.
// - substrate overheat near 144 C enters the fault latch.
module hbridge_drive_fault_control #(
  parameter int unsigned DEAD_CYCLES = `DEAD_CYCLES,
  parameter int unsigned BLANK_CYCLES = `SHORT_BLANK_CYCLES,
  parameter int unsigned CHOP_CYCLES = `CHOP_OFF_CYCLES
) (
  // clock and power-on reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // host pins
  input wire logic drive_input_a_i,
  input wire logic drive_input_b_i,
  input wire logic enable_i,
  // analog comparator results
  input wire logic short_detect_i,
  input wire logic overcurrent_i,
  input wire logic overheat_i,
  input wire logic current_limit_i,
  input wire logic logic_uv_i,
  input wire logic motor_uv_i,
  // switch gate commands
  output hbridge_pkg::switch_set_type switches_o,
  // fault flag
  output logic error_out_n_o
);
  import hbridge_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  drive_mode_type mode;
  drive_mode_type next_mode;
  drive_mode_type last_mode; // last mode driven, kept across idle gaps
  bridge_state_type state;
  logic [`CNT_W-1:0] dead_count;
  logic [`CNT_W-1:0] blank_count;
  logic fault_latch;
  logic chop;
  logic uv;
  switch_set_type next_switches;

  function automatic switch_set_type mode_switches(input drive_mode_type m);
    case (m)
      drive_forward: mode_switches = 4'h9; // high a, low b
      drive_reverse: mode_switches = 4'h6; // high b, low a
      drive_brake_high: mode_switches = 4'hc; // both high sides
      default: mode_switches = 4'h0;
    endcase
  endfunction

  // pick the mode from the pins; brake ignores enable
  always_comb begin
    if (!drive_input_a_i && !drive_input_b_i) begin
      next_mode = drive_brake_high;
    end else if (!enable_i) begin
      next_mode = drive_off;
    end else if (drive_input_a_i && !drive_input_b_i) begin
      next_mode = drive_forward;
    end else if (!drive_input_a_i && drive_input_b_i) begin
      next_mode = drive_reverse;
    end else begin
      next_mode = drive_off;
    end
  end

  assign uv = logic_uv_i || motor_uv_i;

  // ---------------------------------------------------------------
  // fault latch
  // ---------------------------------------------------------------
  // set by short, overcurrent, overheat or logic undervoltage with enable high, cleared by power-on reset only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_latch <= 1'b0;
    end else if ((short_detect_i && blank_count == '0) || overcurrent_i || overheat_i ||
                 (logic_uv_i && enable_i)) begin
      fault_latch <= 1'b1;
    end
  end

  // short detection is blanked right after switching
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blank_count <= '0;
    end else if (next_switches != switches_o) begin
      blank_count <= `CNT_W'(BLANK_CYCLES);
    end else if (blank_count != '0) begin
      blank_count <= blank_count - 1'b1;
    end
  end

  // error flag mirrors the latch
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      error_out_n_o <= 1'b1;
    end else begin
      error_out_n_o <= !fault_latch;
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // a mode change goes through a dead interval with all off
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= st_idle;
      mode <= drive_off;
      dead_count <= '0;
      last_mode <= drive_off;
    end else begin
      case (state)
        st_idle: begin
          if (fault_latch) begin
            state <= st_fault;
          end else if (next_mode != drive_off && !uv) begin
            // a new direction after an enable-low gap still gets the full dead interval
            if (last_mode != drive_off && next_mode != last_mode) begin
              last_mode <= drive_off;
              dead_count <= `CNT_W'(DEAD_CYCLES);
              state <= st_dead;
            end else begin
              mode <= next_mode;
              last_mode <= next_mode;
              state <= st_run;
            end
          end
        end
        st_run: begin
          if (fault_latch) begin
            state <= st_fault;
          end else if (uv || next_mode == drive_off) begin
            mode <= drive_off;
            state <= st_idle; // pwm gating is immediate
          end else if (next_mode != mode) begin
            mode <= drive_off;
            last_mode <= drive_off;
            dead_count <= `CNT_W'(DEAD_CYCLES);
            state <= st_dead;
          end
        end
        st_dead: begin
          if (fault_latch) begin
            state <= st_fault;
          end else if (dead_count <= {{(`CNT_W-1){1'b0}}, 1'b1}) begin
            dead_count <= '0;
            state <= st_idle;
          end else begin
            dead_count <= dead_count - 1'b1;
          end
        end
        st_fault: begin
          mode <= drive_off;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // chopping and outputs
  // ---------------------------------------------------------------
  chop_timer #(
    .OFF_CYCLES(CHOP_CYCLES)
  ) u_chop (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .limit_hit_i(current_limit_i),
    .chop_o(chop)
  );

  // mask everything on fault or undervoltage, chop lows only
  always_comb begin
    next_switches = mode_switches(mode);
    // a pin change away from the running mode drops the drive at the very next edge
    if (state != st_run || next_mode != mode || fault_latch || uv || short_detect_i ||
        overcurrent_i || overheat_i) begin
      next_switches = 4'h0;
    end else if (chop && (mode == drive_forward || mode == drive_reverse)) begin
      next_switches = {next_switches[3:2], 2'b00};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      switches_o <= `SWITCH_RESET;
    end else begin
      switches_o <= next_switches;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_LATCH_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fault_latch |=> switches_o == 4'h0 && !error_out_n_o)
    else $error("switches on or flag high while latched");
  AST_LATCH_HOLDS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fault_latch |=> fault_latch)
    else $error("fault latch released without reset");
  AST_OVERCURRENT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    overcurrent_i |-> ##2 !error_out_n_o)
    else $error("overcurrent not flagged");
  AST_OVERHEAT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    overheat_i |=> switches_o == 4'h0 ##1 !error_out_n_o)
    else $error("overheat not latched");
  AST_UV_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (logic_uv_i || motor_uv_i) |=> switches_o == 4'h0)
    else $error("switches on during undervoltage");
  AST_STOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!enable_i && (drive_input_a_i || drive_input_b_i)) |=> switches_o == 4'h0)
    else $error("bridge driven with enable low");
  AST_NO_SHOOT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(switches_o[3] && switches_o[1]) && !(switches_o[2] && switches_o[0]))
    else $error("shoot-through on a leg");
  AST_DEAD_GAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(switches_o) == 4'h9 && switches_o != 4'h9) |-> switches_o != 4'h6)
    else $error("direction reversed without off interval");
  AST_CHOP_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    chop |=> switches_o[1:0] == 2'b00)
    else $error("low side on during chop");
  AST_LOGIC_FALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (logic_uv_i && enable_i) |-> ##2 !error_out_n_o)
    else $error("supply loss with enable not flagged");
endmodule

/* verification/host_model.sv */
// host controller model driving the direction and enable pins
// assumes wanted levels change by non-blocking assignment at a falling edge
`timescale 1ns/100ps
module host_model (
  // clock and supply state
  input wire logic ref_clk_i,
  input wire logic logic_uv_i,
  // wanted levels
  input wire logic want_a_i,
  input wire logic want_b_i,
  input wire logic want_en_i,
  // host pins
  output logic drive_input_a_o,
  output logic drive_input_b_o,
  output logic enable_o
);
  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // pins start low, which the block decodes as brake once reset ends
  initial begin
    drive_input_a_o = 1'b0;
    drive_input_b_o = 1'b0;
    enable_o = 1'b0;
  end
  // reacts one cycle late, so a supply drop can meet enable high
  always @(negedge ref_clk_i) begin
    drive_input_a_o <= want_a_i;
    drive_input_b_o <= want_b_i;
    enable_o <= want_en_i & ~logic_uv_i;
  end
endmodule

/* verification/hbridge_drive_fault_control_tb.sv */
// self-checking bench for the h-bridge drive and fault control
// assumes host_model beside the block and short counts set here
`timescale 1ns/100ps
module hbridge_drive_fault_control_tb;
  import hbridge_pkg::*;
  localparam int unsigned DEAD = 3;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wa = 1'b0;
  logic wb = 1'b0;
  logic wen = 1'b0;
  logic [3:0] det = 4'h0;
  logic climit = 1'b0;
  logic muv = 1'b0;
  logic pa, pb, pen, error_out_n;
  switch_set_type sw;
  int fails = 0;
  int samples_checked = 0;
  // ---------------------------------------------------------------
  // clock, host and block
  // ---------------------------------------------------------------
  always #5 ref_clk_i = ~ref_clk_i;
  host_model host (.ref_clk_i(ref_clk_i), .logic_uv_i(det[3]), .want_a_i(wa),
    .want_b_i(wb), .want_en_i(wen), .drive_input_a_o(pa), .drive_input_b_o(pb),
    .enable_o(pen));
  hbridge_drive_fault_control #(.DEAD_CYCLES(DEAD), .BLANK_CYCLES(3), .CHOP_CYCLES(5)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .drive_input_a_i(pa), .drive_input_b_i(pb),
    .enable_i(pen), .short_detect_i(det[0]), .overcurrent_i(det[1]),
    .overheat_i(det[2]), .current_limit_i(climit), .logic_uv_i(det[3]),
    .motor_uv_i(muv), .switches_o(sw), .error_out_n_o(error_out_n));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk_sw(input switch_set_type exp);
    samples_checked++;
    if (sw !== exp) begin
      fails++;
      $display("[FAIL] %0t exp %h got %h", $time, exp, sw);
    end
  endtask
  task automatic chk_bit(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic pins(input logic a, input logic b, input logic en);
    @(negedge ref_clk_i);
    wa <= a;
    wb <= b;
    wen <= en;
  endtask
  task automatic wait_sw(input switch_set_type exp);
    for (int i = 0; i < 200 && sw !== exp; i++) @(negedge ref_clk_i);
    chk_sw(exp);
  endtask
  task automatic nap(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic do_reset;
    @(negedge ref_clk_i);
    rst_i <= 1'b1;
    nap(4);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // forward, then enable pulses of 1 us gating the drive
  task automatic s_drive;
    pins(1'b1, 1'b0, 1'b1);
    wait_sw(4'h9);
    repeat (2) begin
      pins(1'b1, 1'b0, 1'b0);
      nap(2);
      chk_sw(4'h0);
      nap(100);
      pins(1'b1, 1'b0, 1'b1);
      wait_sw(4'h9);
    end
  endtask
  // direction change with no host all-off command, or with one enable-low cycle between
  task automatic s_dead(input logic a, input logic via_off);
    int zeros;
    logic clash;
    switch_set_type exp;
    zeros = 0;
    clash = 1'b0;
    exp = a ? 4'h9 : 4'h6;
    if (via_off) pins(!a, a, 1'b0);
    pins(a, !a, 1'b1);
    for (int i = 0; i < 200 && sw !== exp; i++) begin
      @(negedge ref_clk_i);
      zeros += (sw === 4'h0);
      clash |= (sw[3] & sw[1]) | (sw[2] & sw[0]);
    end
    chk_sw(exp);
    chk_bit(1'b1, zeros >= DEAD);
    chk_bit(1'b0, clash);
  endtask
  // brake whatever enable, then standby off
  task automatic s_brake;
    pins(1'b0, 1'b0, 1'b0);
    wait_sw(4'hc);
    pins(1'b0, 1'b0, 1'b1);
    nap(6);
    chk_sw(4'hc);
    pins(1'b1, 1'b1, 1'b0);
    wait_sw(4'h0);
    nap(5);
    chk_sw(4'h0);
  endtask
  // chopping drops only the low side
  task automatic s_chop;
    pins(1'b1, 1'b0, 1'b1);
    wait_sw(4'h9);
    climit <= 1'b1;
    nap(1);
    climit <= 1'b0;
    nap(2);
    chk_sw(4'h8);
    wait_sw(4'h9);
    chk_bit(1'b1, error_out_n);
  endtask
  // undervoltage inhibits without latching
  task automatic s_uv;
    muv <= 1'b1;
    nap(3);
    chk_sw(4'h0);
    chk_bit(1'b1, error_out_n);
    muv <= 1'b0;
    wait_sw(4'h9);
    pins(1'b1, 1'b0, 1'b0);
    wait_sw(4'h0);
    det[3] <= 1'b1;
    pins(1'b1, 1'b0, 1'b1);
    nap(5);
    chk_sw(4'h0);
    chk_bit(1'b1, error_out_n);
    det[3] <= 1'b0;
    wait_sw(4'h9);
  endtask
  // each detector latches off until power-on reset
  task automatic s_fault(input int idx);
    do_reset;
    pins(1'b1, 1'b0, 1'b1);
    wait_sw(4'h9);
    nap(10);
    det <= 4'h1 << idx;
    nap(1);
    det <= 4'h0;
    nap(3);
    chk_sw(4'h0);
    chk_bit(1'b0, error_out_n);
    pins(1'b0, 1'b1, 1'b1);
    nap(20);
    chk_sw(4'h0);
    chk_bit(1'b0, error_out_n);
    do_reset;
    chk_bit(1'b1, error_out_n);
  endtask
  // ---------------------------------------------------------------
  // run and verdict
  // ---------------------------------------------------------------
  task automatic finish_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog well past the several hundred cycles the scenarios need
  initial begin
    #500000;
    fails++;
    finish_test;
  end
  initial begin
    nap(4);
    rst_i <= 1'b0;
    nap(1);
    chk_sw(4'h0);
    chk_bit(1'b1, error_out_n);
    s_drive;
    s_dead(1'b0, 1'b0);
    s_dead(1'b1, 1'b1);
    s_brake;
    s_chop;
    s_uv;
    for (int i = 0; i < 4; i++) s_fault(i);
    finish_test;
  end
endmodule
